//--- hw/txdlw_pkg.sv
// constants and state encoding of the transmit descriptor list walker
package txdlw_pkg;

    // ------------------------------------------------------------------
    // descriptor layout
    // ------------------------------------------------------------------
    localparam logic [31:0] TXDLW_OFS_NEXT   = 32'h0000_0004;
    localparam logic [31:0] TXDLW_OFS_DATA   = 32'h0000_0008;
    localparam logic [31:0] TXDLW_OFS_STATUS = 32'h0000_000c;
    localparam int          TXDLW_BIT_FEND   = 31;
    localparam int          TXDLW_BIT_STOP   = 30;
    localparam int          TXDLW_BIT_HIRQ   = 29;
    localparam int          TXDLW_CNT_MSB    = 28;
    localparam int          TXDLW_CNT_LSB    = 16;
    localparam int          TXDLW_BIT_CMPL   = 30;
    localparam logic [12:0] TXDLW_CNT_MAX    = 13'h1fff;
    localparam logic [1:0]  TXDLW_BURST_LEN  = 2'h3;
    localparam logic [1:0]  TXDLW_SINGLE_LEN = 2'h1;
    localparam logic [31:0] TXDLW_STATUS_DONE = 32'h4000_0000;

    // ------------------------------------------------------------------
    // walker states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        TXDLW_IDLE   = 5'h01,
        TXDLW_FETCH  = 5'h02,
        TXDLW_DATA   = 5'h04,
        TXDLW_WBACK  = 5'h08,
        TXDLW_DECIDE = 5'h10
    } txdlw_state_t;

endpackage

//--- hw/txdlw_walker.sv
// transmit descriptor list walker of one dma channel
`timescale 1ns/10ps

module txdlw_walker (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // host commands and channel configuration
    input  wire logic        action_request_in,
    input  wire logic        init_tx_channel_cmd_in,
    input  wire logic        tx_poll_in,
    input  wire logic        tx_reset_in,
    input  wire logic        list_end_scheme_in,
    input  wire logic [31:0] base_tx_desc_addr_in,
    input  wire logic [31:0] last_tx_desc_addr_in,
    input  wire logic        last_addr_write_in,
    // shared memory master
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic [31:0]      mem_addr_out,
    output logic [1:0]       mem_len_out,
    output logic [31:0]      mem_wdata_out,
    input  wire logic        mem_ack_in,
    input  wire logic [31:0] mem_rdata_in,
    // transmit fifo push side
    output logic             fifo_valid_out,
    output logic [31:0]      fifo_data_out,
    output logic [3:0]       fifo_be_out,
    output logic             fifo_end_out,
    input  wire logic        fifo_ready_in,
    // events and status
    output logic             irq_out,
    output logic             irq_host_flag_out,
    output logic             irq_err_flag_out,
    output logic             tx_active_out,
    output logic [31:0]      cur_desc_addr_out
);

    // ------------------------------------------------------------------
    // state record
    // ------------------------------------------------------------------
    typedef struct packed {
        txdlw_pkg::txdlw_state_t st;

        logic [31:0] desc_addr;
        logic [31:0] next_ptr;
        logic [31:0] data_addr;
        logic [12:0] remaining;
        logic [1:0]  lane;

        logic        frame_end_flag;
        logic        list_stop;
        logic        host_irq_flag;

        logic [1:0]  beat;

        logic        started;
        logic        abort_pend;
        logic        abort_stop;
        logic        aborted;

        logic        mem_req;
        logic        mem_we;
        logic [31:0] mem_addr;
        logic [1:0]  mem_len;
        logic [31:0] mem_wdata;

        logic        fifo_valid;
        logic [31:0] fifo_data;
        logic [3:0]  fifo_be;
        logic        fifo_end;

        logic        irq;
        logic        irq_host;
        logic        irq_err;
    } txdlw_regs_t;

    txdlw_regs_t r;
    txdlw_regs_t next_r;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // lanes lane .. lane+n-1 of a word
    function automatic logic [3:0] txdlw_lane_mask(input logic [1:0] lane,
                                                   input logic [2:0] n);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = (3'(i) >= {1'b0, lane}) && (3'(i) < ({1'b0, lane} + n));
        end
        return m;
    endfunction

    // bytes this word contributes: lanes left in word, capped by remaining
    function automatic logic [2:0] txdlw_take(input logic [1:0]  lane,
                                              input logic [12:0] remaining);
        logic [2:0] avail;
        avail = 3'h4 - {1'b0, lane};
        if (remaining < {10'h000, avail}) begin
            return remaining[2:0];
        end
        return avail;
    endfunction

    function automatic logic [31:0] txdlw_word_align(input logic [31:0] a);
        return {a[31:2], 2'b00};
    endfunction

    logic       init_cmd;
    logic [2:0] take;

    assign init_cmd = action_request_in && init_tx_channel_cmd_in;
    assign take     = txdlw_take(r.lane, r.remaining);

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_r         = r;
        next_r.irq     = 1'b0;
        next_r.irq_host = 1'b0;
        next_r.irq_err = 1'b0;

        case (r.st)
            txdlw_pkg::TXDLW_IDLE: begin
                if (init_cmd) begin
                    next_r.started   = 1'b1;
                    next_r.desc_addr = txdlw_word_align(base_tx_desc_addr_in);
                    next_r.st        = txdlw_pkg::TXDLW_FETCH;
                // poll resumes at the stored next pointer, or fetches from base if never started
                end else if (tx_poll_in) begin
                    next_r.started   = 1'b1;
                    next_r.desc_addr = r.started ? r.next_ptr
                                                 : txdlw_word_align(base_tx_desc_addr_in);
                    next_r.st        = txdlw_pkg::TXDLW_FETCH;
                // new last address reactivates scheme 1
                end else if (last_addr_write_in && list_end_scheme_in && r.started) begin
                    next_r.desc_addr = r.next_ptr;
                    next_r.st        = txdlw_pkg::TXDLW_FETCH;
                end

                if (next_r.st == txdlw_pkg::TXDLW_FETCH) begin
                    next_r.mem_req  = 1'b1;
                    next_r.mem_we   = 1'b0;
                    next_r.mem_addr = next_r.desc_addr;
                    next_r.mem_len  = txdlw_pkg::TXDLW_BURST_LEN;
                    next_r.beat     = 2'h0;
                end
            end

            txdlw_pkg::TXDLW_FETCH: begin
                if (r.mem_req && mem_ack_in) begin
                    next_r.beat = r.beat + 2'h1;

                    case (r.beat)
                        2'h0: begin
                            next_r.frame_end_flag = mem_rdata_in[txdlw_pkg::TXDLW_BIT_FEND];
                            next_r.list_stop      = mem_rdata_in[txdlw_pkg::TXDLW_BIT_STOP];
                            next_r.host_irq_flag  = mem_rdata_in[txdlw_pkg::TXDLW_BIT_HIRQ];
                            next_r.remaining      = mem_rdata_in[txdlw_pkg::TXDLW_CNT_MSB:
                                                                 txdlw_pkg::TXDLW_CNT_LSB];
                        end
                        2'h1: begin
                            next_r.next_ptr = txdlw_word_align(mem_rdata_in);
                        end
                        default: begin
                            // any byte start: word address plus first lane
                            next_r.data_addr  = txdlw_word_align(mem_rdata_in);
                            next_r.lane       = mem_rdata_in[1:0];
                            next_r.mem_req    = 1'b0;
                            next_r.abort_pend = 1'b0;
                            next_r.aborted    = 1'b0;
                            // empty section without frame end is an error
                            if (r.remaining == 13'h0000 && !r.frame_end_flag) begin
                                next_r.irq     = 1'b1;
                                next_r.irq_err = 1'b1;
                                next_r.st      = txdlw_pkg::TXDLW_WBACK;
                            end else begin
                                next_r.st      = txdlw_pkg::TXDLW_DATA;
                            end
                        end
                    endcase
                end
            end

            txdlw_pkg::TXDLW_DATA: begin
                // remember a reset or init seen mid-section
                if (tx_reset_in || init_cmd) begin
                    next_r.abort_pend = 1'b1;
                    next_r.abort_stop = r.abort_stop & r.abort_pend | tx_reset_in;
                end

                if (r.fifo_valid) begin
                    if (fifo_ready_in) begin
                        next_r.fifo_valid = 1'b0;
                        if (r.remaining == 13'h0000) begin
                            // host interrupt once every byte is moved
                            next_r.irq      = r.host_irq_flag;
                            next_r.irq_host = r.host_irq_flag;
                            next_r.st     = txdlw_pkg::TXDLW_WBACK;
                        end
                    end
                end else if (r.mem_req) begin
                    if (mem_ack_in) begin
                        // last bytes of a frame-end section carry the tag
                        next_r.mem_req    = 1'b0;
                        next_r.fifo_valid = 1'b1;
                        next_r.fifo_data  = mem_rdata_in;
                        next_r.fifo_be    = txdlw_lane_mask(r.lane, take);
                        next_r.fifo_end   = r.frame_end_flag &&
                                            (r.remaining == {10'h000, take});
                        next_r.remaining  = r.remaining - {10'h000, take};
                        next_r.lane       = 2'h0;
                        next_r.data_addr  = r.data_addr + 32'h0000_0004;
                    end
                end else if (r.abort_pend || tx_reset_in || init_cmd) begin
                    // abort only between beats so no handshake is cut
                    next_r.aborted    = 1'b1;
                    next_r.abort_stop = r.abort_pend ? (r.abort_stop | tx_reset_in)
                                                     : tx_reset_in;
                    next_r.st         = txdlw_pkg::TXDLW_WBACK;
                end else if (r.remaining == 13'h0000) begin
                    // frame end with no data: a tag-only push
                    next_r.fifo_valid = 1'b1;
                    next_r.fifo_data  = 32'h0000_0000;
                    next_r.fifo_be    = 4'h0;
                    next_r.fifo_end   = 1'b1;
                end else begin
                    next_r.mem_req  = 1'b1;
                    next_r.mem_we   = 1'b0;
                    next_r.mem_addr = r.data_addr;
                    next_r.mem_len  = txdlw_pkg::TXDLW_SINGLE_LEN;
                end

                if (next_r.st == txdlw_pkg::TXDLW_WBACK) begin
                    next_r.mem_req   = 1'b1;
                    next_r.mem_we    = 1'b1;
                    next_r.mem_addr  = r.desc_addr + txdlw_pkg::TXDLW_OFS_STATUS;
                    next_r.mem_len   = txdlw_pkg::TXDLW_SINGLE_LEN;
                    // completion on normal end or abort
                    next_r.mem_wdata = txdlw_pkg::TXDLW_STATUS_DONE;
                end
            end

            txdlw_pkg::TXDLW_WBACK: begin
                // error path enters here without a pending request
                // last of four words
                if (!r.mem_req) begin
                    next_r.mem_req   = 1'b1;
                    next_r.mem_we    = 1'b1;
                    next_r.mem_addr  = r.desc_addr + txdlw_pkg::TXDLW_OFS_STATUS;
                    next_r.mem_len   = txdlw_pkg::TXDLW_SINGLE_LEN;
                    next_r.mem_wdata = txdlw_pkg::TXDLW_STATUS_DONE;
                end else if (mem_ack_in) begin
                    next_r.mem_req = 1'b0;
                    next_r.mem_we  = 1'b0;
                    next_r.st      = txdlw_pkg::TXDLW_DECIDE;
                end
            end

            txdlw_pkg::TXDLW_DECIDE: begin
                next_r.st = txdlw_pkg::TXDLW_IDLE;
                if (r.aborted) begin
                    // branch to base instead of the next pointer
                    next_r.next_ptr = txdlw_word_align(base_tx_desc_addr_in);
                    if (!r.abort_stop) begin
                        next_r.desc_addr = txdlw_word_align(base_tx_desc_addr_in);
                        next_r.st        = txdlw_pkg::TXDLW_FETCH;
                    end
                end else if (!list_end_scheme_in) begin
                    if (!r.list_stop) begin
                        next_r.desc_addr = r.next_ptr;
                        next_r.st        = txdlw_pkg::TXDLW_FETCH;
                    end
                end else begin
                    // compare against the stored last address
                    if (r.desc_addr != txdlw_word_align(last_tx_desc_addr_in)) begin
                        next_r.desc_addr = r.next_ptr;
                        next_r.st        = txdlw_pkg::TXDLW_FETCH;
                    end
                end

                if (next_r.st == txdlw_pkg::TXDLW_FETCH) begin
                    next_r.mem_req  = 1'b1;
                    next_r.mem_we   = 1'b0;
                    next_r.mem_addr = next_r.desc_addr;
                    next_r.mem_len  = txdlw_pkg::TXDLW_BURST_LEN;
                    next_r.beat     = 2'h0;
                end
            end

            default: begin
                next_r.st      = txdlw_pkg::TXDLW_IDLE;
                next_r.mem_req = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            r    <= '0;
            r.st <= txdlw_pkg::TXDLW_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign mem_req_out       = r.mem_req;
    assign mem_we_out        = r.mem_we;
    assign mem_addr_out      = r.mem_addr;
    assign mem_len_out       = r.mem_len;
    assign mem_wdata_out     = r.mem_wdata;

    assign fifo_valid_out    = r.fifo_valid;
    assign fifo_data_out     = r.fifo_data;
    assign fifo_be_out       = r.fifo_be;
    assign fifo_end_out      = r.fifo_end;

    assign irq_out           = r.irq;
    assign irq_host_flag_out = r.irq_host;
    assign irq_err_flag_out  = r.irq_err;

    assign tx_active_out     = (r.st != txdlw_pkg::TXDLW_IDLE);
    assign cur_desc_addr_out = r.desc_addr;

endmodule

//--- bench/txdlw_walker_asserts.sv
// concurrent checks on the ports of the transmit descriptor list walker
`timescale 1ns/10ps

module txdlw_walker_asserts (
    input wire logic        ref_clk_in,
    input wire logic        reset_in,
    input wire logic        action_request_in,
    input wire logic        init_tx_channel_cmd_in,
    input wire logic        tx_poll_in,
    input wire logic        last_addr_write_in,
    input wire logic [31:0] base_tx_desc_addr_in,
    input wire logic        mem_ack_in,
    input wire logic        fifo_ready_in,
    input wire logic        mem_req_out,
    input wire logic        mem_we_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic [1:0]  mem_len_out,
    input wire logic [31:0] mem_wdata_out,
    input wire logic        fifo_valid_out,
    input wire logic [31:0] fifo_data_out,
    input wire logic [3:0]  fifo_be_out,
    input wire logic        fifo_end_out,
    input wire logic        irq_out,
    input wire logic        irq_host_flag_out,
    input wire logic        irq_err_flag_out,
    input wire logic        tx_active_out,
    input wire logic [31:0] cur_desc_addr_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    AST_INIT_FETCH: assert property (
        !tx_active_out && action_request_in && init_tx_channel_cmd_in |=> mem_req_out
        && !mem_we_out && mem_len_out == 2'h3
        && mem_addr_out == ($past(base_tx_desc_addr_in) & 32'hffff_fffc))
        else $error("init did not start a burst fetch at the base address");
    AST_POLL_FETCH: assert property (
        !tx_active_out && tx_poll_in |=> mem_req_out && !mem_we_out && mem_len_out == 2'h3)
        else $error("poll in idle did not start a burst fetch");
    AST_CMD_ONLY: assert property (
        $rose(tx_active_out) |-> ($past(action_request_in) && $past(init_tx_channel_cmd_in))
        || $past(tx_poll_in) || $past(last_addr_write_in))
        else $error("walker left idle without a command");
    AST_IDLE_QUIET: assert property (
        !tx_active_out |-> !mem_req_out && !fifo_valid_out)
        else $error("memory or fifo activity while idle");
    AST_REQ_HOLD: assert property (
        mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
        && $stable(mem_len_out) && $stable(mem_we_out))
        else $error("memory request changed before acknowledge");
    AST_WB_WORD: assert property (
        mem_req_out && mem_we_out |-> mem_wdata_out == 32'h4000_0000 && mem_len_out == 2'h1
        && mem_addr_out == cur_desc_addr_out + 32'hc)
        else $error("writeback word or address wrong");
    AST_FIFO_HOLD: assert property (
        fifo_valid_out && !fifo_ready_in |=> fifo_valid_out && $stable(fifo_data_out)
        && $stable(fifo_be_out) && $stable(fifo_end_out))
        else $error("fifo push changed before accept");
    AST_FIFO_GAP: assert property (
        fifo_valid_out && fifo_ready_in |=> !fifo_valid_out)
        else $error("fifo pushes back to back");
    AST_IRQ_PULSE: assert property (
        irq_out |=> !irq_out)
        else $error("interrupt longer than one cycle");
    AST_IRQ_CAUSE: assert property (
        irq_out == (irq_host_flag_out || irq_err_flag_out))
        else $error("interrupt without cause or cause without interrupt");
    AST_HOST_IRQ: assert property (
        irq_out && irq_host_flag_out |-> $past(fifo_valid_out) && $past(fifo_ready_in))
        else $error("host interrupt not right after last push");
endmodule

bind txdlw_walker txdlw_walker_asserts chk_u (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .action_request_in(action_request_in),
    .init_tx_channel_cmd_in(init_tx_channel_cmd_in), .tx_poll_in(tx_poll_in),
    .last_addr_write_in(last_addr_write_in), .base_tx_desc_addr_in(base_tx_desc_addr_in),
    .mem_ack_in(mem_ack_in), .fifo_ready_in(fifo_ready_in), .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_len_out(mem_len_out),
    .mem_wdata_out(mem_wdata_out), .fifo_valid_out(fifo_valid_out),
    .fifo_data_out(fifo_data_out), .fifo_be_out(fifo_be_out), .fifo_end_out(fifo_end_out),
    .irq_out(irq_out), .irq_host_flag_out(irq_host_flag_out),
    .irq_err_flag_out(irq_err_flag_out), .tx_active_out(tx_active_out),
    .cur_desc_addr_out(cur_desc_addr_out));

//--- bench/txdlw_mem_model.sv
// shared memory model answering the walker's memory master
`timescale 1ns/10ps

module txdlw_mem_model (
    input  wire logic        ref_clk_in,
    input  wire logic        req_in,
    input  wire logic        we_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [1:0]  len_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        slow_in,
    output logic             ack_out,
    output logic [31:0]      rdata_out
);
    logic [31:0] mem [0:127];
    logic [1:0]  beat = 2'h0;
    logic [1:0]  nbeat;
    logic        nack;
    logic [6:0]  base;

    initial ack_out = 1'b0;
    initial rdata_out = 32'h0;
    assign base  = addr_in[8:2];
    assign nbeat = ack_out ? beat + 2'h1 : beat;
    // whole burst acked, gaps when slow
    assign nack  = req_in && !(ack_out && nbeat == len_in) && !(slow_in && ack_out);

    always @(posedge ref_clk_in) begin
        if (ack_out && we_in) mem[base + 7'(beat)] <= wdata_in;
        beat    <= (nbeat == len_in) ? 2'h0 : nbeat;
        ack_out <= nack;
        // idle data bus toggles so a stale read never looks valid
        rdata_out <= nack ? mem[base + 7'(nbeat)] : ~rdata_out;
    end
endmodule

//--- bench/test_tx_descriptor_list_walker.sv
// self-checking bench of the transmit descriptor list walker
`timescale 1ns/10ps

module test_tx_descriptor_list_walker;
    logic        ref_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        action_request_in = 1'b0;
    logic        init_tx_channel_cmd_in = 1'b0;
    logic        tx_poll_in = 1'b0;
    logic        tx_reset_in = 1'b0;
    logic        list_end_scheme_in = 1'b0;
    logic [31:0] base_tx_desc_addr_in = 32'h0000_0040;
    logic [31:0] last_tx_desc_addr_in = 32'h0000_0070;
    logic        last_addr_write_in = 1'b0;
    logic        fifo_ready_in = 1'b1;
    logic        slow = 1'b0;
    logic        req_q = 1'b0;
    logic        mem_req_out, mem_we_out, mem_ack_in, fifo_valid_out, fifo_end_out;
    logic        irq_out, irq_host_flag_out, irq_err_flag_out, tx_active_out;
    logic [1:0]  mem_len_out;
    logic [3:0]  fifo_be_out;
    logic [31:0] mem_addr_out, mem_wdata_out, mem_rdata_in, fifo_data_out, cur_desc_addr_out;
    logic [31:0] fetch_q [$];
    logic [4:0]  push_q [$];
    int          host_irqs, err_irqs, cyc, bad_count, check_count;

    always #20 ref_clk_in = ~ref_clk_in;

    txdlw_walker dut_u (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .action_request_in(action_request_in), .init_tx_channel_cmd_in(init_tx_channel_cmd_in),
        .tx_poll_in(tx_poll_in), .tx_reset_in(tx_reset_in),
        .list_end_scheme_in(list_end_scheme_in), .base_tx_desc_addr_in(base_tx_desc_addr_in),
        .last_tx_desc_addr_in(last_tx_desc_addr_in), .last_addr_write_in(last_addr_write_in),
        .mem_req_out(mem_req_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
        .mem_len_out(mem_len_out), .mem_wdata_out(mem_wdata_out), .mem_ack_in(mem_ack_in),
        .mem_rdata_in(mem_rdata_in), .fifo_valid_out(fifo_valid_out),
        .fifo_data_out(fifo_data_out), .fifo_be_out(fifo_be_out), .fifo_end_out(fifo_end_out),
        .fifo_ready_in(fifo_ready_in), .irq_out(irq_out), .irq_host_flag_out(irq_host_flag_out),
        .irq_err_flag_out(irq_err_flag_out), .tx_active_out(tx_active_out),
        .cur_desc_addr_out(cur_desc_addr_out));

    txdlw_mem_model mem_u (.ref_clk_in(ref_clk_in), .req_in(mem_req_out), .we_in(mem_we_out),
        .addr_in(mem_addr_out), .len_in(mem_len_out), .wdata_in(mem_wdata_out),
        .slow_in(slow), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));

    // ------------------------------------------------------------------
    // monitor and run limit
    // ------------------------------------------------------------------
    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        req_q <= mem_req_out;
        if (mem_req_out && !req_q && !mem_we_out && mem_len_out == 2'h3)
            fetch_q.push_back(mem_addr_out);
        if (fifo_valid_out && fifo_ready_in) push_q.push_back({fifo_end_out, fifo_be_out});
        if (irq_out === 1'b1) begin
            host_irqs += int'(irq_host_flag_out);
            err_irqs += int'(irq_err_flag_out);
        end
        if (cyc == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // kind: 0 init action request, 1 poll, 2 transmitter reset, 3 new last address
    task automatic cmd(input int kind);
        @(posedge ref_clk_in);
        action_request_in <= (kind == 0);
        init_tx_channel_cmd_in <= (kind == 0);
        tx_poll_in <= (kind == 1);
        tx_reset_in <= (kind == 2);
        last_addr_write_in <= (kind == 3);
        @(posedge ref_clk_in);
        {action_request_in, init_tx_channel_cmd_in, tx_poll_in} <= 3'h0;
        {tx_reset_in, last_addr_write_in} <= 2'h0;
    endtask

    task automatic wait_idle();
        @(posedge ref_clk_in);
        while (tx_active_out !== 1'b0) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask

    task automatic clear();
        fetch_q.delete();
        push_q.delete();
        host_irqs = 0;
        err_irqs = 0;
    endtask

    // descriptor complete before the walker can reach it
    task automatic put_desc(input logic [31:0] at, input logic [31:0] w0, input logic [31:0] nxt);
        mem_u.mem[at[8:2]] = w0;
        mem_u.mem[at[8:2] + 7'h1] = nxt;
        mem_u.mem[at[8:2] + 7'h2] = (at == 32'h40) ? 32'h0000_0102 : 32'h0000_0100;
        mem_u.mem[at[8:2] + 7'h3] = 32'hffff_ffff;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic scen_stop_scheme();
        clear();
        cmd(0);
        wait_idle();
        check("first fetch", fetch_q[0], 32'h40);
        check("branch fetch", fetch_q[1], 32'h50);
        check("fetch count", 32'(fetch_q.size()), 32'h2);
        check("push one", 32'(push_q[0]), 32'h0c);
        check("push two", 32'(push_q[1]), 32'h11);
        check("host irq", 32'(host_irqs), 32'h1);
        check("error irq", 32'(err_irqs), 32'h1);
        check("status one", mem_u.mem[7'h13], 32'h4000_0000);
        check("status two", mem_u.mem[7'h17], 32'h4000_0000);
        check("fifo data", fifo_data_out, 32'h5a5a_0f0f);
        cmd(1);
        wait_idle();
        check("poll fetch", fetch_q[2], 32'h60);
        check("aligned push", 32'(push_q[2]), 32'h0f);
    endtask

    task automatic scen_addr_scheme();
        clear();
        @(posedge ref_clk_in);
        slow <= 1'b1;
        list_end_scheme_in <= 1'b1;
        base_tx_desc_addr_in <= 32'h0000_0060;
        cmd(0);
        wait_idle();
        check("stop flag ignored", fetch_q[1], 32'h70);
        check("stop at last", 32'(fetch_q.size()), 32'h2);
        check("tag only", 32'(push_q[1]), 32'h10);
        @(posedge ref_clk_in) last_tx_desc_addr_in <= 32'h0000_0050;
        cmd(3);
        wait_idle();
        check("resume fetch", fetch_q[2], 32'h40);
        check("resume count", 32'(fetch_q.size()), 32'h4);
        @(posedge ref_clk_in);
        slow <= 1'b0;
        list_end_scheme_in <= 1'b0;
        base_tx_desc_addr_in <= 32'h0000_0040;
    endtask

    task automatic scen_abort(input int kind);
        clear();
        mem_u.mem[7'h13] = 32'hffff_ffff;
        @(posedge ref_clk_in) fifo_ready_in <= 1'b0;
        cmd(0);
        while (fifo_valid_out !== 1'b1) @(posedge ref_clk_in);
        cmd(kind);
        @(posedge ref_clk_in) fifo_ready_in <= 1'b1;
        wait_idle();
        check("abort status", mem_u.mem[7'h13], 32'h4000_0000);
        if (kind == 2) begin
            check("abort pushes", 32'(push_q.size()), 32'h1);
            check("no irq on abort", 32'(host_irqs), 32'h0);
            cmd(1);
            wait_idle();
        end
        check("refetch base", fetch_q[1], 32'h40);
    endtask

    initial begin
        repeat (4) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        put_desc(32'h40, {1'b1, 1'b0, 1'b1, 13'h0003, 16'h0}, 32'h50);
        put_desc(32'h50, {1'b0, 1'b1, 1'b0, 13'h0000, 16'h0}, 32'h60);
        put_desc(32'h60, {1'b0, 1'b1, 1'b0, 13'h0004, 16'h0}, 32'h70);
        put_desc(32'h70, {1'b1, 1'b0, 1'b0, 13'h0000, 16'h0}, 32'h40);
        mem_u.mem[7'h41] = 32'h5a5a_0f0f;
        scen_stop_scheme();
        scen_addr_scheme();
        scen_abort(2);
        scen_abort(0);
        end_of_test();
    end
endmodule
